// File: rtl/ec_mailbox_pkg.sv
package ec_mailbox_pkg;

    localparam int NUM_LANES = 4;

    // Controller-side register indices; byte address is four times the index
    localparam logic [9:0] IDX_DATA0    = 10'h100;
    localparam logic [9:0] IDX_DATA3    = 10'h103;
    localparam logic [9:0] IDX_STATUS   = 10'h104;
    localparam logic [9:0] IDX_WIDTH    = 10'h105;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h110;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h111;
    localparam logic [9:0] IDX_NOTIFY   = 10'h112;

    // Host-side window offsets
    localparam logic [2:0] HOST_DATA0  = 3'h0;
    localparam logic [2:0] HOST_DATA3  = 3'h3;
    localparam logic [2:0] HOST_STATUS = 3'h4;
    localparam logic [2:0] HOST_WIDTH  = 3'h5;

    // Field positions
    localparam int OBF_BIT          = 0;
    localparam int WIDTH_BIT        = 0;
    localparam int IRQ_DRAINED_BIT  = 0;
    localparam int IRQ_LOADED_BIT   = 1;
    localparam int NOTIFY_BIT       = 0;

    // Reset values
    localparam logic       WIDTH_RESET = 1'b0;
    localparam logic       OBF_RESET   = 1'b0;
    localparam logic [1:0] IRQ_RESET   = 2'h0;
    localparam logic [7:0] LANE_RESET  = 8'h00;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } host_req_type;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_type;

endpackage

// File: rtl/obf_flag.sv
`timescale 1ns/10ps
module obf_flag (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic set_evt,
    input  wire logic clr_evt,
    output logic      flag_q,
    output logic      drained_q
);
    import ec_mailbox_pkg::*;

    always_ff @(posedge CLK) begin
        if (RST) begin
            flag_q <= OBF_RESET;
        end else if (set_evt) begin
            flag_q <= 1'b1;
        end else if (clr_evt) begin
            flag_q <= 1'b0;
        end
    end

    // Drained only when the read really empties the flag
    always_ff @(posedge CLK) begin
        if (RST) begin
            drained_q <= 1'b0;
        end else begin
            drained_q <= clr_evt & flag_q & ~set_evt;
        end
    end

    property p_set_wins;
        @(posedge CLK) disable iff (RST) set_evt && clr_evt |=> flag_q;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat set");

    property p_rise_cause;
        @(posedge CLK) disable iff (RST) $rose(flag_q) |-> $past(set_evt);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("flag rose unset");

endmodule

// File: rtl/ec_mailbox_obf.sv
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module ec_mailbox_obf (
    input  wire logic                         CLK,
    input  wire logic                         RST,
    input  wire logic [11:0]                  AVS_ADDRESS,
    input  wire logic                         AVS_READ,
    input  wire logic                         AVS_WRITE,
    input  wire logic [3:0]                   AVS_BYTEENABLE,
    input  wire logic [31:0]                  AVS_WRITEDATA,
    output logic      [31:0]                  AVS_READDATA,
    output logic                              AVS_WAITREQUEST,
    input  wire ec_mailbox_pkg::host_req_type HOST_REQ,
    output logic      [7:0]                   HOST_RDATA,
    output logic                              HOST_NOTIFY,
    output logic                              HOST_DRAINED,
    output logic                              IRQ
);
    import ec_mailbox_pkg::*;

    bus_state_type bus_state_q;
    logic [7:0]    lane_q [NUM_LANES];
    logic          width_q;
    logic [1:0]    irq_stat_q;
    logic [1:0]    irq_mask_q;
    logic [31:0]   readdata_q;
    logic [7:0]    host_rdata_q;
    logic          notify_q;
    logic [9:0]    idx;
    logic          accept;
    logic          ec_wr;
    logic          ec_rd;
    logic          obf_set;
    logic          obf_clr;
    logic          obf_q;
    logic          drained_q;
    logic          width_wr;
    logic          width_d;
    logic [1:0]    irq_clr;

    assign idx    = AVS_ADDRESS[11:2];
    assign accept = (AVS_READ | AVS_WRITE) & (bus_state_q == BUS_ACK);
    assign ec_wr  = accept & AVS_WRITE & AVS_BYTEENABLE[0];
    assign ec_rd  = accept & AVS_READ;

    // One wait cycle per access; read data registered in that cycle
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & (bus_state_q != BUS_ACK);
    assign AVS_READDATA    = readdata_q;
    assign HOST_RDATA      = host_rdata_q;
    assign HOST_NOTIFY     = notify_q;
    assign HOST_DRAINED    = drained_q;
    assign IRQ             = |(irq_stat_q & irq_mask_q);

    always_ff @(posedge CLK) begin
        if (RST) begin
            bus_state_q <= BUS_IDLE;
        end else begin
            case (bus_state_q)
                BUS_IDLE: begin
                    if (AVS_READ | AVS_WRITE) begin
                        bus_state_q <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    bus_state_q <= BUS_IDLE;
                end
                default: begin
                    bus_state_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // Lane data as seen by either side
    function automatic logic [7:0] lane_view(input logic [1:0] lane);
        logic [7:0] v;
        v = 8'h00;
        if (width_q || lane == 2'h0) begin
            v = lane_q[lane];
        end
        return v;
    endfunction

    function automatic logic [7:0] ec_view(input logic [9:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a >= IDX_DATA0 && a <= IDX_DATA3) begin
            v = lane_view(a[1:0]);
        end else if (a == IDX_STATUS) begin
            v[OBF_BIT] = obf_q;
        end else if (a == IDX_WIDTH) begin
            v[WIDTH_BIT] = width_q;
        end else if (a == IDX_IRQ_STAT) begin
            v[1:0] = irq_stat_q;
        end else if (a == IDX_IRQ_MASK) begin
            v[1:0] = irq_mask_q;
        end
        return v;
    endfunction

    always_ff @(posedge CLK) begin
        if (RST) begin
            readdata_q <= 32'h00000000;
        end else if (bus_state_q == BUS_IDLE && AVS_READ) begin
            readdata_q <= {24'h000000, ec_view(idx)};
        end
    end

    // Lane storage; narrow mode drops lanes 1-3
    for (genvar i = 0; i < NUM_LANES; i++) begin : g_lane
        always_ff @(posedge CLK) begin
            if (RST) begin
                lane_q[i] <= LANE_RESET;
            end else if (ec_wr && idx == IDX_DATA0 + 10'(i) && (width_q || i == 0)) begin
                lane_q[i] <= AVS_WRITEDATA[7:0];
            end
        end
    end

    // Flag set and clear lanes follow the width bit
    assign obf_set = ec_wr & (idx == (width_q ? IDX_DATA3 : IDX_DATA0));
    assign obf_clr = HOST_REQ.rd
                   & (HOST_REQ.addr == (width_q ? HOST_DATA3 : HOST_DATA0));

    obf_flag u_obf (
        .CLK       (CLK),
        .RST       (RST),
        .set_evt   (obf_set),
        .clr_evt   (obf_clr),
        .flag_q    (obf_q),
        .drained_q (drained_q)
    );

    // One width bit behind both address views; controller wins a collision
    assign width_wr = (ec_wr & (idx == IDX_WIDTH))
                    | (HOST_REQ.wr & (HOST_REQ.addr == HOST_WIDTH));
    assign width_d  = (ec_wr & (idx == IDX_WIDTH)) ? AVS_WRITEDATA[WIDTH_BIT]
                                                   : HOST_REQ.wdata[WIDTH_BIT];

    always_ff @(posedge CLK) begin
        if (RST) begin
            width_q <= WIDTH_RESET;
        end else if (width_wr) begin
            width_q <= width_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            host_rdata_q <= 8'h00;
        end else if (HOST_REQ.rd) begin
            if (HOST_REQ.addr <= HOST_DATA3) begin
                host_rdata_q <= lane_view(HOST_REQ.addr[1:0]);
            end else if (HOST_REQ.addr == HOST_STATUS) begin
                host_rdata_q <= {7'h00, obf_q};
            end else if (HOST_REQ.addr == HOST_WIDTH) begin
                host_rdata_q <= {7'h00, width_q};
            end else begin
                host_rdata_q <= 8'h00;
            end
        end
    end

    // Firmware doorbell toward the host
    always_ff @(posedge CLK) begin
        if (RST) begin
            notify_q <= 1'b0;
        end else begin
            notify_q <= ec_wr & (idx == IDX_NOTIFY) & AVS_WRITEDATA[NOTIFY_BIT];
        end
    end

    // Clear only bits that the read returned, so late events survive
    assign irq_clr = (ec_rd && idx == IDX_IRQ_STAT) ? readdata_q[1:0] : 2'h0;

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat_q <= IRQ_RESET;
        end else begin
            irq_stat_q[IRQ_DRAINED_BIT] <= (irq_stat_q[IRQ_DRAINED_BIT]
                & ~irq_clr[IRQ_DRAINED_BIT]) | drained_q;
            irq_stat_q[IRQ_LOADED_BIT]  <= (irq_stat_q[IRQ_LOADED_BIT]
                & ~irq_clr[IRQ_LOADED_BIT]) | obf_set;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_mask_q <= IRQ_RESET;
        end else if (ec_wr && idx == IDX_IRQ_MASK) begin
            irq_mask_q <= AVS_WRITEDATA[1:0];
        end
    end

    property p_narrow_set;
        @(posedge CLK) disable iff (RST)
        ec_wr && !width_q && idx == IDX_DATA0 |=> obf_q;
    endproperty
    a_narrow_set: assert property (p_narrow_set) else $error("lane0 write no flag");

    property p_narrow_clr;
        @(posedge CLK) disable iff (RST)
        HOST_REQ.rd && !width_q && HOST_REQ.addr == HOST_DATA0 && !obf_set |=> !obf_q;
    endproperty
    a_narrow_clr: assert property (p_narrow_clr) else $error("lane0 read no clear");

    property p_wide_lane0_no_set;
        @(posedge CLK) disable iff (RST)
        width_q && !obf_q && ec_wr && idx == IDX_DATA0 && !width_wr |=> !obf_q;
    endproperty
    a_wide_lane0_no_set: assert property (p_wide_lane0_no_set) else $error("wide lane0 set");

    property p_wide_set;
        @(posedge CLK) disable iff (RST)
        ec_wr && width_q && idx == IDX_DATA3 |=> obf_q;
    endproperty
    a_wide_set: assert property (p_wide_set) else $error("lane3 write no flag");

    property p_wide_clr;
        @(posedge CLK) disable iff (RST)
        HOST_REQ.rd && width_q && HOST_REQ.addr == HOST_DATA3 && !obf_set |=> !obf_q;
    endproperty
    a_wide_clr: assert property (p_wide_clr) else $error("lane3 read no clear");

    property p_drained;
        @(posedge CLK) disable iff (RST)
        obf_q && obf_clr && !obf_set |=> HOST_DRAINED ##1 irq_stat_q[IRQ_DRAINED_BIT];
    endproperty
    a_drained: assert property (p_drained) else $error("drain not signalled");

    property p_notify;
        @(posedge CLK) disable iff (RST)
        ec_wr && idx == IDX_NOTIFY && AVS_WRITEDATA[NOTIFY_BIT] |=> HOST_NOTIFY;
    endproperty
    a_notify: assert property (p_notify) else $error("doorbell lost");

    property p_narrow_zero;
        @(posedge CLK) disable iff (RST)
        HOST_REQ.rd && !width_q && HOST_REQ.addr != HOST_DATA0 && HOST_REQ.addr <= HOST_DATA3
        && !obf_set |=> HOST_RDATA == 8'h00 && $stable(obf_q);
    endproperty
    a_narrow_zero: assert property (p_narrow_zero) else $error("upper lane visible");

    property p_narrow_drop;
        @(posedge CLK) disable iff (RST)
        ec_wr && !width_q && idx == IDX_DATA3 |=> $stable(lane_q[3]);
    endproperty
    a_narrow_drop: assert property (p_narrow_drop) else $error("lane3 stored");

    property p_alias;
        @(posedge CLK) disable iff (RST)
        HOST_REQ.wr && HOST_REQ.addr == HOST_WIDTH && !(ec_wr && idx == IDX_WIDTH)
        |=> width_q == $past(HOST_REQ.wdata[WIDTH_BIT]);
    endproperty
    a_alias: assert property (p_alias) else $error("host width lost");

    property p_wait_one;
        @(posedge CLK) disable iff (RST)
        AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest too long");

    c_narrow_cycle: cover property (@(posedge CLK) disable iff (RST)
        !width_q && obf_set ##[1:20] obf_clr);
    c_wide_cycle: cover property (@(posedge CLK) disable iff (RST)
        width_q && obf_set ##[1:20] obf_clr);
    c_collide: cover property (@(posedge CLK) disable iff (RST) obf_set && obf_clr);
    c_irq: cover property (@(posedge CLK) disable iff (RST) $rose(IRQ));

endmodule

// File: dv/host_model.sv
`timescale 1ns/10ps
module host_model (
    input  wire logic                    CLK,
    input  wire logic [7:0]              HOST_RDATA,
    output ec_mailbox_pkg::host_req_type HOST_REQ
);
    import ec_mailbox_pkg::*;

    initial HOST_REQ = '0;

    // Idle address and data show inverted values and rd/wr drop to zero so stale data is never mistaken
    task automatic host_op(input logic w, input logic [2:0] a, input logic [7:0] v,
                           output logic [7:0] d);
        @(posedge CLK);
        HOST_REQ <= '{rd: ~w, wr: w, addr: a, wdata: v};
        @(posedge CLK);
        HOST_REQ <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
        @(posedge CLK);
        d = HOST_RDATA;
    endtask

    task automatic host_rd(input logic [2:0] a, output logic [7:0] d);
        host_op(1'b0, a, 8'h00, d);
    endtask

    task automatic host_wr(input logic [2:0] a, input logic [7:0] v);
        logic [7:0] d;
        host_op(1'b1, a, v, d);
    endtask

    // Status first, then, if OBF is set, as many lanes as the selected width
    task automatic host_drain(input logic wide, output logic [31:0] d);
        logic [7:0] s;
        logic [7:0] b;
        d = '0;
        host_rd(HOST_STATUS, s);
        if (s[OBF_BIT] === 1'b1) begin
            for (int i = 0; i < (wide ? 4 : 1); i++) begin
                host_rd(3'(i), b);
                d[8*i +: 8] = b;
            end
        end
    endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/10ps
module tb;
    import ec_mailbox_pkg::*;

    logic         clk;
    logic         rst;
    logic [11:0]  avs_address;
    logic         avs_read;
    logic         avs_write;
    logic [3:0]   avs_byteenable;
    logic [31:0]  avs_writedata;
    logic [31:0]  avs_readdata;
    logic         avs_waitrequest;
    host_req_type host_req;
    logic [7:0]   host_rdata;
    logic         host_notify;
    logic         host_drained;
    logic         irq;
    int           error_cnt = 0;
    int           check_count = 0;
    int           drained_cnt = 0;
    int           notify_cnt = 0;
    int           cyc = 0;
    logic [7:0]   b;
    logic [31:0]  d;

    ec_mailbox_obf i_ec_mailbox_obf (
        .CLK(clk), .RST(rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_BYTEENABLE(avs_byteenable),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .HOST_REQ(host_req), .HOST_RDATA(host_rdata),
        .HOST_NOTIFY(host_notify), .HOST_DRAINED(host_drained), .IRQ(irq)
    );

    host_model i_host_model (.CLK(clk), .HOST_RDATA(host_rdata), .HOST_REQ(host_req));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (host_drained === 1'b1) drained_cnt <= drained_cnt + 1;
        if (host_notify === 1'b1) notify_cnt <= notify_cnt + 1;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic avs_rd(input logic [9:0] idx, output logic [31:0] v);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read    <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic avs_wr(input logic [9:0] idx, input logic [7:0] v,
                          input logic [3:0] be = 4'h1);
        @(posedge clk);
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {24'h0, v};
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        avs_rd(idx, v);
        check(v, exp);
    endtask

    initial begin
        rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata = '0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(IDX_STATUS, 32'h0);
        rd_chk(IDX_WIDTH, 32'h0);
        i_host_model.host_rd(HOST_WIDTH, b);
        check({24'h0, b}, 32'h0);
        $display("test reset done");
        avs_wr(IDX_DATA0, 8'ha5);
        rd_chk(IDX_STATUS, 32'h1);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        avs_wr(IDX_IRQ_MASK, 8'h03);
        @(negedge clk);
        check({31'h0, irq}, 32'h1);
        i_host_model.host_wr(HOST_STATUS, 8'h00);
        rd_chk(IDX_STATUS, 32'h1);
        i_host_model.host_rd(HOST_DATA0 + 3'h1, b);
        check({24'h0, b}, 32'h0);
        avs_wr(IDX_DATA0 + 10'h1, 8'h5a);
        rd_chk(IDX_DATA0 + 10'h1, 32'h0);
        rd_chk(IDX_STATUS, 32'h1);
        i_host_model.host_drain(1'b0, d);
        check(d, 32'h0000_00a5);
        rd_chk(IDX_STATUS, 32'h0);
        check(drained_cnt, 32'h1);
        rd_chk(IDX_IRQ_STAT, 32'h3);
        rd_chk(IDX_IRQ_STAT, 32'h0);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        avs_wr(IDX_NOTIFY, 8'h01);
        repeat (3) @(posedge clk);
        check(notify_cnt, 32'h1);
        $display("test narrow done");
        i_host_model.host_wr(HOST_WIDTH, 8'h01);
        rd_chk(IDX_WIDTH, 32'h1);
        rd_chk(IDX_DATA0 + 10'h1, 32'h0);
        for (int i = 0; i < 3; i++) begin
            avs_wr(IDX_DATA0 + 10'(i), 8'h10 + 8'(i));
            rd_chk(IDX_STATUS, 32'h0);
        end
        avs_wr(IDX_DATA3, 8'h13);
        rd_chk(IDX_STATUS, 32'h1);
        i_host_model.host_rd(HOST_DATA0, b);
        rd_chk(IDX_STATUS, 32'h1);
        i_host_model.host_drain(1'b1, d);
        check(d, 32'h1312_1110);
        rd_chk(IDX_STATUS, 32'h0);
        check(drained_cnt, 32'h2);
        avs_wr(IDX_DATA3, 8'h77);
        fork
            avs_wr(IDX_DATA3, 8'h88);
            begin
                @(posedge clk);
                i_host_model.host_rd(HOST_DATA3, b);
            end
        join
        rd_chk(IDX_STATUS, 32'h1);
        check(drained_cnt, 32'h2);
        $display("test wide done");
        avs_wr(IDX_WIDTH, 8'h00, 4'h0);
        i_host_model.host_rd(HOST_WIDTH, b);
        check({24'h0, b}, 32'h1);
        avs_wr(IDX_WIDTH, 8'h00);
        i_host_model.host_rd(HOST_WIDTH, b);
        check({24'h0, b}, 32'h0);
        avs_wr(10'h200, 8'hff);
        rd_chk(10'h200, 32'h0);
        $display("test alias done");
        results();
    end
endmodule
